// [rtl/dscg_clock_gen.sv]
// Dual source CPU clock generator with standby and oscillator control
`timescale 1ns/1ns
// How it works
// - Reset clears both control registers: slowest main rate, normal mode.
// - On main clock, divider code 00,01,10,11 gives main/64,/16,/8,/4.
// - Upper mode bits: 00 normal, 01 halt, 10 stop, 11 prohibited.
// - A standby release clears both mode bits; after stop the CPU stays held until wait release.
// - Stop instruction sets bit 3, halt instruction sets bit 2.
// - A nibble write updates divider bits only; mode bits forced to zero.
// - Stop and halt instructions work regardless of the bank enable flag.
// - On subclock the divider bits are ignored; CPU runs subclock/4.
// - Stop entry only on main clock; halt stays available on subclock.
// - Select bit picks main or subclock; stop bit with subclock stops main.
// - Single-bit access to select and stop bits ignores the bank flag.
// - Stop bit halts main oscillator only on subclock; else stop mode.
// - Main oscillator input grounded while stop bit set; no external clock.
// - Divided clocks feed peripherals; watch timer gets the raw subclock.
// - Watch timer runs on subclock; others unusable with main stopped.
// - The subsystem oscillator can never be stopped.
// - Stop mode grounds the main oscillator input.
// - Halt offered on subclock with main stopped; stop not offered.
// - A select rewrite takes effect after a bounded number of CPU cycles.
module dscg_clock_gen
    import dscg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic main_tick_i,
    input wire logic sub_tick_i,
    input wire logic [11:0] mem_addr_i,
    input wire logic nib_wr_i,
    input wire logic [3:0] nib_wdata_i,
    input wire logic bit_set_i,
    input wire logic bit_clr_i,
    input wire logic [1:0] bit_pos_i,
    input wire logic stop_instr_i,
    input wire logic halt_instr_i,
    input wire logic standby_release_i,
    input wire logic wait_release_i,
    output logic [3:0] processor_clock_control_o,
    output logic [3:0] system_clock_select_o,
    output logic cpu_clk_o,
    output logic cpu_cycle_o,
    output logic cpu_run_o,
    output logic main_osc_enable_o,
    output logic main_osc_input_pin_ground_o,
    output logic sub_osc_enable_o,
    output logic use_subclock_o,
    output logic [DSCG_PRESCALE_W-1:0] periph_clk_o,
    output logic periph_clk_valid_o,
    output logic watch_clk_o,
    output logic halt_mode_o,
    output logic stop_mode_o
);
    logic [3:0] pcc_reg;
    logic [3:0] pcc_next;
    logic [3:0] scc_reg;
    logic [3:0] scc_next;
    logic sub_active_reg;
    logic [1:0] div_active_reg;
    logic [5:0] switch_cnt_reg;
    logic switch_pend_reg;
    logic stop_wait_reg;
    logic [DSCG_PRESCALE_W-1:0] prescale_reg;
    logic [5:0] half_sel;
    logic src_tick;
    logic div_level;
    logic div_edge;
    logic pcc_hit;
    logic scc_hit;
    logic main_stopped;
    dscg_mode_t mode;

    ////////////////////////////////////////////////////////////////////////
    // Register decode and next values
    ////////////////////////////////////////////////////////////////////////

    assign pcc_hit = (mem_addr_i == DSCG_PCC_ADDR);
    assign scc_hit = (mem_addr_i == DSCG_SCC_ADDR);
    assign mode = dscg_mode_t'(pcc_reg[DSCG_STOP_BIT:DSCG_HALT_BIT]);
    // Main oscillator halted by the stop bit on subclock or by stop mode
    assign main_stopped = (scc_reg[DSCG_OSCSTOP_BIT] && sub_active_reg)
        || pcc_reg[DSCG_STOP_BIT];

    // Control register next value; instructions outrank a plain write
    always_comb begin
        pcc_next = pcc_reg;
        if (nib_wr_i && pcc_hit) begin
            pcc_next = {2'h0, nib_wdata_i[DSCG_DIV_HI_BIT:DSCG_DIV_LO_BIT]};
        end
        if (standby_release_i) begin
            pcc_next[DSCG_STOP_BIT] = 1'b0;
            pcc_next[DSCG_HALT_BIT] = 1'b0;
        end
        // No bank flag input: stop acts only on main clock; otherwise halt acts
        if (stop_instr_i && !sub_active_reg && !scc_reg[DSCG_SUBSEL_BIT]) begin
            pcc_next[DSCG_STOP_BIT] = 1'b1;
        end else if (halt_instr_i) begin
            pcc_next[DSCG_HALT_BIT] = 1'b1;
        end
    end

    // Select register next value: bit operations on bits 0 and 3 only
    // Positions 00 and 11 map onto bits 0 and 3; 01 and 10 are ignored
    always_comb begin
        scc_next = scc_reg;
        if (scc_hit && bit_set_i && (bit_pos_i[1] == bit_pos_i[0])) begin
            scc_next[{bit_pos_i[0], bit_pos_i[0]}] = 1'b1;
        end else if (scc_hit && bit_clr_i
            && (bit_pos_i[1] == bit_pos_i[0])) begin
            scc_next[{bit_pos_i[0], bit_pos_i[0]}] = 1'b0;
        end else if (scc_hit && nib_wr_i) begin
            scc_next[DSCG_SUBSEL_BIT] = nib_wdata_i[DSCG_SUBSEL_BIT];
            scc_next[DSCG_OSCSTOP_BIT] = nib_wdata_i[DSCG_OSCSTOP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    ////////////////////////////////////////////////////////////////////////

    // Processor clock control register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pcc_reg <= DSCG_PCC_RESET;
        end else begin
            pcc_reg <= pcc_next;
        end
    end

    // System clock select register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            scc_reg <= DSCG_SCC_RESET;
        end else begin
            scc_reg <= scc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delayed clock switching
    ////////////////////////////////////////////////////////////////////////

    // Keep running on the old selection for a fixed count of CPU cycles
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sub_active_reg <= 1'b0;
            div_active_reg <= DSCG_DIV64;
            switch_cnt_reg <= 6'h00;
            switch_pend_reg <= 1'b0;
        end else if ((scc_next[DSCG_SUBSEL_BIT] != scc_reg[DSCG_SUBSEL_BIT])
            || (pcc_next[1:0] != pcc_reg[1:0])) begin
            switch_pend_reg <= 1'b1;
            switch_cnt_reg <= 6'h00;
        end else if (switch_pend_reg && (cpu_cycle_o || main_stopped)) begin
            if (switch_cnt_reg >= DSCG_SWITCH_CYCLES - 6'h01) begin
                switch_pend_reg <= 1'b0;
                sub_active_reg <= scc_reg[DSCG_SUBSEL_BIT];
                div_active_reg <= pcc_reg[1:0];
            end else begin
                switch_cnt_reg <= switch_cnt_reg + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // CPU clock divider
    ////////////////////////////////////////////////////////////////////////

    // Half period in source ticks for the active selection
    always_comb begin
        if (sub_active_reg) begin
            half_sel = DSCG_HALFSUB;
        end else begin
            case (div_active_reg)
                DSCG_DIV64: half_sel = DSCG_HALF64;
                DSCG_DIV16: half_sel = DSCG_HALF16;
                DSCG_DIV8: half_sel = DSCG_HALF8;
                DSCG_DIV4: half_sel = DSCG_HALF4;
                default: half_sel = DSCG_HALF64;
            endcase
        end
    end

    // Source tick: subclock always runs, main tick gated when stopped
    assign src_tick = sub_active_reg ? sub_tick_i
        : (main_tick_i && !main_stopped);

    dscg_tick_div u_cpu_div (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(src_tick),
        .run_i(1'b1),
        .half_i(half_sel),
        .level_o(div_level),
        .edge_o(div_edge)
    );

    ////////////////////////////////////////////////////////////////////////
    // Standby and stop release wait
    ////////////////////////////////////////////////////////////////////////

    // After stop ends, hold the CPU until oscillation is stable
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            stop_wait_reg <= 1'b0;
        end else if (pcc_reg[DSCG_STOP_BIT] && !pcc_next[DSCG_STOP_BIT]) begin
            stop_wait_reg <= 1'b1;
        end else if (wait_release_i) begin
            stop_wait_reg <= 1'b0;
        end
    end

    // CPU clock gated in standby and during the stop release wait
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cpu_clk_o <= 1'b0;
            cpu_cycle_o <= 1'b0;
            cpu_run_o <= 1'b0;
        end else begin
            cpu_run_o <= (mode == DSCG_MODE_NORMAL) && !stop_wait_reg;
            cpu_clk_o <= div_level && (mode == DSCG_MODE_NORMAL)
                && !stop_wait_reg;
            cpu_cycle_o <= div_edge && (mode == DSCG_MODE_NORMAL)
                && !stop_wait_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator control and peripheral clocks
    ////////////////////////////////////////////////////////////////////////

    // Main oscillator enable and input grounding
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            main_osc_enable_o <= 1'b1;
            main_osc_input_pin_ground_o <= 1'b0;
            sub_osc_enable_o <= 1'b1;
        end else begin
            main_osc_enable_o <= !main_stopped;
            main_osc_input_pin_ground_o <= scc_reg[DSCG_OSCSTOP_BIT]
                || pcc_reg[DSCG_STOP_BIT];
            sub_osc_enable_o <= 1'b1;
        end
    end

    // Peripheral prescaler counts main ticks; frozen while main stops
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            prescale_reg <= '0;
        end else if (main_tick_i && !main_stopped) begin
            prescale_reg <= prescale_reg + 12'h001;
        end
    end

    // Peripheral outputs and watch timer clock
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            periph_clk_o <= '0;
            periph_clk_valid_o <= 1'b1;
            watch_clk_o <= 1'b0;
        end else begin
            periph_clk_o <= prescale_reg;
            periph_clk_valid_o <= !main_stopped;
            watch_clk_o <= sub_tick_i;
        end
    end

    // Register views and mode status
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            processor_clock_control_o <= DSCG_PCC_RESET;
            system_clock_select_o <= DSCG_SCC_RESET;
            use_subclock_o <= 1'b0;
            halt_mode_o <= 1'b0;
            stop_mode_o <= 1'b0;
        end else begin
            processor_clock_control_o <= pcc_next;
            system_clock_select_o <= scc_next;
            use_subclock_o <= sub_active_reg;
            halt_mode_o <= (dscg_mode_t'(pcc_next[3:2]) == DSCG_MODE_HALT);
            stop_mode_o <= (dscg_mode_t'(pcc_next[3:2]) == DSCG_MODE_STOP);
        end
    end
endmodule : dscg_clock_gen

// [rtl/dscg_pkg.sv]
// Package for the dual source CPU clock generator: addresses, fields, counts
package dscg_pkg;
    // Register addresses in data memory
    localparam logic [11:0] DSCG_PCC_ADDR = 12'hFB3;
    localparam logic [11:0] DSCG_SCC_ADDR = 12'hFB7;
    // Values after reset
    localparam logic [3:0] DSCG_PCC_RESET = 4'h0;
    localparam logic [3:0] DSCG_SCC_RESET = 4'h0;
    // Field positions
    localparam int DSCG_DIV_LO_BIT = 0;
    localparam int DSCG_DIV_HI_BIT = 1;
    localparam int DSCG_HALT_BIT = 2;
    localparam int DSCG_STOP_BIT = 3;
    localparam int DSCG_SUBSEL_BIT = 0;
    localparam int DSCG_OSCSTOP_BIT = 3;
    // Divider codes and half periods in source ticks (subclock ticks for DSCG_HALFSUB)
    localparam logic [1:0] DSCG_DIV64 = 2'h0;
    localparam logic [1:0] DSCG_DIV16 = 2'h1;
    localparam logic [1:0] DSCG_DIV8 = 2'h2;
    localparam logic [1:0] DSCG_DIV4 = 2'h3;
    localparam logic [5:0] DSCG_HALF64 = 6'h20;
    localparam logic [5:0] DSCG_HALF16 = 6'h08;
    localparam logic [5:0] DSCG_HALF8 = 6'h04;
    localparam logic [5:0] DSCG_HALF4 = 6'h02;
    localparam logic [5:0] DSCG_HALFSUB = 6'h02;
    // Machine cycles the old clock is kept after a select rewrite
    localparam logic [5:0] DSCG_SWITCH_CYCLES = 6'h20;
    // Peripheral prescaler width (divides by up to 4096)
    localparam int DSCG_PRESCALE_W = 12;
    // Operating modes held in the upper two control bits
    typedef enum logic [1:0] {
        DSCG_MODE_NORMAL,
        DSCG_MODE_HALT,
        DSCG_MODE_STOP,
        DSCG_MODE_BAD
    } dscg_mode_t;
endpackage : dscg_pkg

// [rtl/dscg_tick_div.sv]
// Tick divider: toggles a clock level every half period of enable ticks
`timescale 1ns/1ns
module dscg_tick_div
    import dscg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic [5:0] half_i,
    output logic level_o,
    output logic edge_o
);
    logic [5:0] cnt_reg;

    // Count ticks; a rising level edge marks one whole period
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 6'h00;
            level_o <= 1'b0;
            edge_o <= 1'b0;
        end else begin
            edge_o <= 1'b0;
            if (run_i && tick_i) begin
                if (cnt_reg >= half_i - 6'h01) begin
                    cnt_reg <= 6'h00;
                    level_o <= ~level_o;
                    edge_o <= ~level_o;
                end else begin
                    cnt_reg <= cnt_reg + 6'h01;
                end
            end
        end
    end
endmodule : dscg_tick_div

// [verif/dscg_clock_gen_sva.sv]
// Checker bound to the clock generator ports
`timescale 1ns/1ns
module dscg_clock_gen_sva
    import dscg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [11:0] mem_addr_i,
    input wire logic nib_wr_i,
    input wire logic [3:0] nib_wdata_i,
    input wire logic stop_instr_i,
    input wire logic halt_instr_i,
    input wire logic standby_release_i,
    input wire logic sub_tick_i,
    input wire logic [3:0] processor_clock_control_o,
    input wire logic [3:0] system_clock_select_o,
    input wire logic cpu_run_o,
    input wire logic main_osc_enable_o,
    input wire logic main_osc_input_pin_ground_o,
    input wire logic sub_osc_enable_o,
    input wire logic periph_clk_valid_o,
    input wire logic watch_clk_o,
    input wire logic halt_mode_o,
    input wire logic stop_mode_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic [3:0] ctl = processor_clock_control_o;
    wire logic [3:0] sel = system_clock_select_o;
    wire logic instr = stop_instr_i | halt_instr_i;
    wire logic ctl_wr = nib_wr_i && mem_addr_i == DSCG_PCC_ADDR;
    ////////////////////////////////////////////////////////////////////////
    // Register views, standby modes and clock sources
    chk_reset_clear: assert property ($rose(rst_b_i) |-> {ctl, sel} == 8'h00)
        else $error("registers not clear");
    chk_write_mask: assert property (ctl_wr && !instr && !standby_release_i
        |=> ctl == {2'h0, $past(nib_wdata_i[1:0])}) else $error("bad write");
    chk_halt_set: assert property (halt_instr_i && !stop_instr_i
        |=> ctl[2] && halt_mode_o) else $error("halt not taken");
    chk_stop_refuse: assert property (stop_instr_i && sel[0] && $past(sel[0])
        |=> !ctl[3] && !stop_mode_o) else $error("stop taken on subclock");
    chk_release_clear: assert property (standby_release_i && !instr
        |=> ctl[3:2] == 2'h0) else $error("mode bits kept");
    chk_halt_gate: assert property (halt_mode_o [*2] |-> !cpu_run_o)
        else $error("CPU runs in halt");
    chk_sub_free: assert property ($past(rst_b_i) |-> sub_osc_enable_o
        && watch_clk_o == $past(sub_tick_i)) else $error("subclock path");
    chk_pin_ground: assert property ((sel[3] || stop_mode_o) [*2]
        |-> main_osc_input_pin_ground_o) else $error("input not grounded");
    chk_osc_runs: assert property ((!(sel[3] || stop_mode_o)) [*2]
        |-> main_osc_enable_o) else $error("main stopped");
    chk_periph_gate: assert property ((!main_osc_enable_o) [*2]
        |-> !periph_clk_valid_o) else $error("periph valid");
endmodule : dscg_clock_gen_sva

bind dscg_clock_gen dscg_clock_gen_sva chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .mem_addr_i(mem_addr_i), .nib_wr_i(nib_wr_i), .nib_wdata_i(nib_wdata_i),
    .stop_instr_i(stop_instr_i), .halt_instr_i(halt_instr_i),
    .standby_release_i(standby_release_i), .sub_tick_i(sub_tick_i),
    .processor_clock_control_o(processor_clock_control_o),
    .system_clock_select_o(system_clock_select_o), .cpu_run_o(cpu_run_o),
    .main_osc_enable_o(main_osc_enable_o),
    .main_osc_input_pin_ground_o(main_osc_input_pin_ground_o),
    .sub_osc_enable_o(sub_osc_enable_o), .watch_clk_o(watch_clk_o),
    .periph_clk_valid_o(periph_clk_valid_o), .halt_mode_o(halt_mode_o),
    .stop_mode_o(stop_mode_o));

// [verif/dscg_osc_model.sv]
// Oscillator model: main and subsystem tick sources
`timescale 1ns/1ns
module dscg_osc_model #(
    parameter int SUB_DIV = 10
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic main_osc_enable_i,
    output logic main_tick_o,
    output logic sub_tick_o
);
    logic main_reg = 1'b0;
    logic sub_reg = 1'b0;
    logic [7:0] cnt_reg = 8'h00;
    assign main_tick_o = main_reg;
    assign sub_tick_o = sub_reg;
    ////////////////////////////////////////////////////////////////////////
    // Crystal main source ticks only while enabled, below the fast limit
    always @(posedge clk_i) begin
        main_reg <= rst_b_i && main_osc_enable_i;
    end
    // Subsystem crystal never stops
    always @(posedge clk_i) begin
        cnt_reg <= (cnt_reg == 8'(SUB_DIV - 1)) ? 8'h00 : cnt_reg + 8'h01;
        sub_reg <= cnt_reg == 8'h00;
    end
endmodule : dscg_osc_model

// [verif/tb_top.sv]
// Testbench for the dual source CPU clock generator
`timescale 1ns/1ns
module tb_top;
    import dscg_pkg::*;
    localparam logic [5:0] WR = 6'h20, SET = 6'h10, CLR = 6'h08;
    localparam logic [5:0] STP = 6'h04, HLT = 6'h02, REL = 6'h01;
    localparam logic [11:0] PER [4] = '{12'h040, 12'h010, 12'h008, 12'h004};
    logic clk_i = 1'b0, rst_b_i = 1'b0, main_tick, sub_tick, probe = 1'b0;
    logic nib_wr_i = 1'b0, bit_set_i = 1'b0, bit_clr_i = 1'b0;
    logic stop_instr_i = 1'b0, halt_instr_i = 1'b0, standby_release_i = 1'b0;
    logic wait_release_i = 1'b0, seen = 1'b0, cpu_cycle, cpu_run, osc_en;
    logic [11:0] mem_addr_i = 12'h000, gap = 12'h000;
    logic [3:0] nib_wdata_i = 4'h0, ctl, sel;
    logic [1:0] bit_pos_i = 2'h0;
    logic [31:0] r, cycles = 32'h0;
    int fail_count = 0, checked = 0;
    logic [7:0] reg_q[$];
    logic [11:0] per_q[$];
    logic run_q[$];
    dscg_osc_model #(.SUB_DIV(10)) osc (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .main_osc_enable_i(osc_en), .main_tick_o(main_tick),
        .sub_tick_o(sub_tick));
    dscg_clock_gen dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .main_tick_i(main_tick), .sub_tick_i(sub_tick),
        .mem_addr_i(mem_addr_i), .nib_wr_i(nib_wr_i),
        .nib_wdata_i(nib_wdata_i), .bit_set_i(bit_set_i),
        .bit_clr_i(bit_clr_i), .bit_pos_i(bit_pos_i),
        .stop_instr_i(stop_instr_i), .halt_instr_i(halt_instr_i),
        .standby_release_i(standby_release_i),
        .wait_release_i(wait_release_i), .processor_clock_control_o(ctl),
        .system_clock_select_o(sel), .cpu_clk_o(), .cpu_cycle_o(cpu_cycle),
        .cpu_run_o(cpu_run), .main_osc_enable_o(osc_en),
        .main_osc_input_pin_ground_o(), .sub_osc_enable_o(),
        .use_subclock_o(), .periph_clk_o(), .periph_clk_valid_o(),
        .watch_clk_o(), .halt_mode_o(), .stop_mode_o());
    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial forever #5 clk_i = ~clk_i;
    // One access or instruction per edge, expected views noted
    task automatic op(input logic [5:0] s, input logic [11:0] a,
            input logic [3:0] d, input logic [7:0] e);
        @(posedge clk_i);
        {nib_wr_i, bit_set_i, bit_clr_i} <= s[5:3];
        {stop_instr_i, halt_instr_i, standby_release_i} <= s[2:0];
        mem_addr_i <= a;
        nib_wdata_i <= d;
        bit_pos_i <= d[1:0];
        reg_q.push_back(e);
    endtask : op
    task automatic idle();
        op(6'h00, 12'h000, 4'h0, 8'h00);
        void'(reg_q.pop_back());
    endtask : idle
    // Wait out the switch, then note the CPU cycle length
    task automatic per(input logic [11:0] p);
        repeat (36) @(posedge clk_i iff cpu_cycle);
        @(negedge clk_i);
        per_q.push_back(p);
        repeat (2) @(posedge clk_i iff cpu_cycle);
    endtask : per
    task automatic run_is(input logic e);
        @(posedge clk_i);
        run_q.push_back(e);
        probe <= 1'b1;
        @(posedge clk_i);
        probe <= 1'b0;
    endtask : run_is
    task automatic cmp(input string n, input logic [11:0] e,
            input logic [11:0] s);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic conclude();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////
    // Watcher: cycle lengths, access flags and the cycle ceiling
    always @(posedge clk_i) begin
        seen <= nib_wr_i | bit_set_i | bit_clr_i | (|s_instr());
        gap <= cpu_cycle ? 12'h001 : gap + 12'h001;
        if (cpu_cycle && per_q.size() != 0) cmp("period", per_q.pop_front(), gap);
        cycles <= cycles + 32'h1;
        if (cycles == 32'h00004E20) begin
            fail_count++;
            conclude();
        end
    end
    function automatic logic [2:0] s_instr();
        return {stop_instr_i, halt_instr_i, standby_release_i};
    endfunction : s_instr
    // Register views one cycle after each access
    always @(negedge clk_i) begin
        if (seen) cmp("regs", {4'h0, reg_q.pop_front()}, {4'h0, ctl, sel});
        if (probe) cmp("cpu_run", {11'h0, run_q.pop_front()}, {11'h0, cpu_run});
    end
    // Main sequence
    initial begin
        void'($urandom(2));
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        op(WR, 12'hFB5, 4'hF, 8'h00);
        for (int i = 3; i >= 0; i--) begin
            r = $urandom;
            op(WR, DSCG_PCC_ADDR, {r[3:2], 2'(i)}, {2'h0, 2'(i), 4'h0});
            idle();
            per(PER[i]);
        end
        op(SET, DSCG_SCC_ADDR, 4'h0, 8'h01);
        idle();
        per(12'h028);
        op(WR, DSCG_PCC_ADDR, 4'h3, 8'h31);
        idle();
        per(12'h028);
        op(STP, 12'h000, 4'h0, 8'h31);
        op(HLT, 12'h000, 4'h0, 8'h71);
        idle();
        run_is(1'b0);
        op(REL, 12'h000, 4'h0, 8'h31);
        idle();
        repeat (12) @(posedge clk_i);
        op(SET, DSCG_SCC_ADDR, 4'h3, 8'h39);
        op(SET, DSCG_SCC_ADDR, 4'h1, 8'h39);
        idle();
        run_is(1'b1);
        op(CLR, DSCG_SCC_ADDR, 4'h3, 8'h31);
        op(CLR, DSCG_SCC_ADDR, 4'h0, 8'h30);
        idle();
        per(12'h004);
        op(STP | HLT, 12'h000, 4'h0, 8'hB0);
        idle();
        run_is(1'b0);
        op(REL, 12'h000, 4'h0, 8'h30);
        idle();
        run_is(1'b0);
        wait_release_i <= 1'b1;
        @(posedge clk_i);
        wait_release_i <= 1'b0;
        per(12'h004);
        conclude();
    end
endmodule : tb_top
